// *** pkg/serial_config_consts.svh ***
/*
  Constants of the passive serial configuration loader: bus offsets, field positions,
  reset values and timing counts.
  Assumes a system clock of 25 MHz and a byte-addressed Wishbone slave.
*/
`ifndef SERIAL_CONFIG_CONSTS_SVH
`define SERIAL_CONFIG_CONSTS_SVH

// Register byte offsets.
`define CFG_OFS_CTRL          8'h00
`define CFG_OFS_LENGTH        8'h04
`define CFG_OFS_STATUS        8'h08
`define CFG_OFS_COUNT         8'h0C

// Control register fields.
`define CFG_CTRL_AUTO_BIT     0
`define CFG_CTRL_UCLK_BIT     1
`define CFG_CTRL_RESET        2'h1

// Image length register, in bytes, last byte being the checksum.
`define CFG_LENGTH_RESET      16'h0010

// Status register fields.
`define CFG_STAT_STATE_LSB    0
`define CFG_STAT_USER_BIT     4
`define CFG_STAT_ERR_BIT      8

// Timing: system clock rate and the fault reset timeout (longest, rounds down).
`define CFG_CLK_MHZ           25
`define CFG_TIMEOUT_US        100
`define CFG_TIMEOUT_CYC       (`CFG_TIMEOUT_US * `CFG_CLK_MHZ)

// Initialization cycles and the internal oscillator divider.
`define CFG_INIT_CYCLES       299
`define CFG_OSC_DIV           3

`endif

// *** pkg/serial_config_pkg.sv ***
/*
  Types shared by the configuration loader modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_config_pkg;

  // Loader states.
  typedef enum logic [2:0] {
    ST_RESET,
    ST_ERROR,
    ST_WAIT_RELEASE,
    ST_LOAD,
    ST_WAIT_DONE,
    ST_INIT,
    ST_USER
  } cfg_state_t;

  // Pin indices inside the synchroniser bank.
  typedef enum int {
    PIN_RESTART,
    PIN_FAULT,
    PIN_DONE,
    PIN_CHAIN,
    PIN_SCLK,
    PIN_SDATA,
    PIN_UCLK,
    PIN_COUNT
  } pin_idx_t;

endpackage

// *** pkg/pin_sync_if.sv ***
/*
  Carrier between the loader and its synchroniser bank: raw pin levels in, synchronised
  levels out.
  Assumes both ends run on the same system clock.
*/
interface pin_sync_if #(parameter int WIDTH = 7);
  logic [WIDTH-1:0] raw;   // Levels straight from the pins.
  logic [WIDTH-1:0] sync;  // Levels after two flip-flops.

  // The loader drives raw pins and reads the synchronised copy.
  modport user (output raw, input sync);
  // The synchroniser bank.
  modport bank (input raw, output sync);
endinterface

// *** design/pin_sync_bank.sv ***
/*
  Two flip-flop synchroniser for a bank of asynchronous pin inputs.
  Assumes the raw levels come from outside the system clock domain.
*/
module pin_sync_bank #(
  parameter int WIDTH = 7
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Pin levels and their synchronised copies.
  pin_sync_if.bank pins
);

  logic [WIDTH-1:0] first;  // Metastable stage, read only by the second stage.
  logic [WIDTH-1:0] second; // Stable stage.

  // Both stages are plain registers; nothing else reads the first stage.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      first  <= '0;
      second <= '0;
    end else begin
      first  <= pins.raw;
      second <= first;
    end
  end

  assign pins.sync = second;

endmodule // pin_sync_bank

// *** design/serial_config_loader.sv ***
/*
  Passive serial configuration loader of a volatile programmable device, with a classic
  Wishbone slave for control and status.
  Assumes the configuration source drives the serial clock (far slower than clk_sys),
  the lane data and the wired-AND fault and load-complete lines with external pull-ups.
*/
// Chosen here: the Wishbone register port and the register addresses.
// Functional notes
// - Error while loading: drive fault low, reset.
// - Auto restart releases fault within 100 us.
// - Tied load-complete lines start initialization together.
// - Restart low in user mode starts reconfiguration.
// - Restart low: fault, done low, pins tri-stated.
// - Reload only after restart high, fault released.
// - Chain enables daisy-chained, first tied low.
// - Finished device drives chain enable out low.
// - Loading waits until shared fault line high.
// - Any fault low stops and resets whole chain; here user mode ignores it.
// - Capture lane zero on serial clock rise.
// - Release load-complete after good data received.
// - Count 299 initialization clocks, then user mode.
`include "serial_config_consts.svh"

module serial_config_loader (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Classic Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // Configuration pins from the source and the chain.
  input  wire logic        serial_load_clock,
  input  wire logic        serial_lane_zero,
  input  wire logic        restart_request_n,
  input  wire logic        chain_enable_in_n,
  input  wire logic        user_startup_clock,
  output logic             chain_enable_out_n,
  // Open-drain fault line.
  input  wire logic        fault_hold_n_in,
  output logic             fault_hold_n_out,
  output logic             fault_hold_n_oe,
  // Open-drain load-complete line.
  input  wire logic        load_complete_in,
  output logic             load_complete_out,
  output logic             load_complete_oe,
  // Device state towards the user logic.
  output logic             io_tristate,
  output logic             user_mode
);
  import serial_config_pkg::*;

  localparam logic [11:0] TIMEOUT_LAST = 12'(`CFG_TIMEOUT_CYC - 1);
  localparam logic [11:0] INIT_LAST    = 12'(`CFG_INIT_CYCLES - 1);
  localparam logic [1:0]  OSC_LAST     = 2'(`CFG_OSC_DIV - 1);

  pin_sync_if #(.WIDTH(PIN_COUNT)) pins ();  // Raw and synchronised pins.

  // Every pin crosses two flip-flops before the loader reads it.
  pin_sync_bank #(.WIDTH(PIN_COUNT)) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pins    (pins)
  );

  assign pins.raw[PIN_RESTART] = restart_request_n;
  assign pins.raw[PIN_FAULT]   = fault_hold_n_in;
  assign pins.raw[PIN_DONE]    = load_complete_in;
  assign pins.raw[PIN_CHAIN]   = chain_enable_in_n;
  assign pins.raw[PIN_SCLK]    = serial_load_clock;
  assign pins.raw[PIN_SDATA]   = serial_lane_zero;
  assign pins.raw[PIN_UCLK]    = user_startup_clock;

  logic restart_s;  // Restart request, high when idle.
  logic fault_s;    // Shared fault line as seen on the wire.
  logic done_s;     // Shared load-complete line as seen on the wire.
  logic chain_s;    // Chain enable input, low when this device may load.
  assign restart_s = pins.sync[PIN_RESTART];
  assign fault_s   = pins.sync[PIN_FAULT];
  assign done_s    = pins.sync[PIN_DONE];
  assign chain_s   = pins.sync[PIN_CHAIN];

  // Loader state.
  cfg_state_t  state, next_state;            // Main sequence.
  logic [11:0] count, next_count;            // Timeout and initialization counter.
  logic [2:0]  bit_cnt, next_bit_cnt;        // Bit position inside a byte.
  logic [7:0]  shift, next_shift;            // Byte being assembled.
  logic [15:0] byte_cnt, next_byte_cnt;      // Bytes received so far.
  logic [7:0]  sum, next_sum;                // Running checksum of the payload.
  logic        sclk_d, uclk_d;               // Previous clock levels for edge finding.
  logic [1:0]  osc, next_osc;                // Internal oscillator divider.
  logic        err_flag, next_err_flag;      // Sticky load error for software.

  // Software-visible control.
  logic [1:0]  ctrl, next_ctrl;              // Auto restart and user clock select.
  logic [15:0] length, next_length;          // Image length in bytes.
  logic        next_ack;                     // Bus answer.
  logic [31:0] next_dat;                     // Read data.

  logic sclk_rise;  // Serial clock rising edge.
  logic uclk_rise;  // User startup clock rising edge.
  logic osc_tick;   // Internal oscillator tick.
  logic init_tick;  // One initialization clock.
  logic wr_fire;    // A write takes effect this edge.
  logic [7:0] byte_in; // Completed byte including the new bit.

  assign sclk_rise = pins.sync[PIN_SCLK] & ~sclk_d;
  assign uclk_rise = pins.sync[PIN_UCLK] & ~uclk_d;
  assign osc_tick  = (osc == OSC_LAST);
  assign init_tick = ctrl[`CFG_CTRL_UCLK_BIT] ? uclk_rise : osc_tick;
  assign wr_fire   = cyc_i & stb_i & we_i & ack_o;
  // Lane zero arrives least significant bit first.
  assign byte_in   = {pins.sync[PIN_SDATA], shift[7:1]};

  // Sequence: reset, error timeout, wait for release, load, done, init, user.
  always_comb begin
    next_state    = state;
    next_count    = count;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_byte_cnt = byte_cnt;
    next_sum      = sum;
    next_err_flag = err_flag;
    next_osc      = osc_tick ? 2'h0 : osc + 2'h1;
    // Software clears the error flag by writing one; an error found below still wins.
    if (wr_fire && adr_i == `CFG_OFS_STATUS && sel_i[1] && dat_i[`CFG_STAT_ERR_BIT]) begin
      next_err_flag = 1'b0;
    end
    case (state)
      ST_RESET: begin
        // Held here while restart is low; leaving releases the fault line.
        if (restart_s) begin
          next_state = ST_WAIT_RELEASE;
        end
      end
      ST_ERROR: begin
        // Fault held low for the timeout, then auto restart leaves; a restart request leaves at any time.
        if (count == TIMEOUT_LAST) begin
          if (ctrl[`CFG_CTRL_AUTO_BIT]) begin
            next_state = ST_WAIT_RELEASE;
          end
        end else begin
          next_count = count + 12'h001;
        end
      end
      ST_WAIT_RELEASE: begin
        // Loading waits until every party has released the fault line.
        next_bit_cnt  = 3'h0;
        next_byte_cnt = 16'h0000;
        next_sum      = 8'h00;
        next_count    = 12'h000;
        if (fault_s) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (!fault_s) begin
          // Someone in the chain flagged an error: drop everything.
          next_state = ST_WAIT_RELEASE;
        end else if (sclk_rise && !chain_s) begin
          // Only an enabled device takes bits from the lane.
          next_shift   = byte_in;
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            next_byte_cnt = byte_cnt + 16'h0001;
            if (byte_cnt == length - 16'h0001) begin
              // Last byte is the checksum of the payload.
              if (byte_in == sum) begin
                next_state = ST_WAIT_DONE;
              end else begin
                // Bad image: reset ourselves and hold the fault line.
                next_state    = ST_ERROR;
                next_count    = 12'h000;
                next_err_flag = 1'b1;
              end
            end else begin
              next_sum = sum + byte_in;
            end
          end
        end
      end
      ST_WAIT_DONE: begin
        // Wait for the tied load-complete line, so the chain starts together.
        if (!fault_s) begin
          next_state = ST_WAIT_RELEASE;
        end else if (done_s) begin
          next_state = ST_INIT;
          next_count = 12'h000;
        end
      end
      ST_INIT: begin
        if (!fault_s) begin
          next_state = ST_WAIT_RELEASE;
        end else if (init_tick) begin
          if (count == INIT_LAST) begin
            next_state = ST_USER;
          end else begin
            next_count = count + 12'h001;
          end
        end
      end
      ST_USER: begin
        // User mode is left only through a restart request.
        next_state = ST_USER;
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    // A low restart request overrides every state.
    if (!restart_s) begin
      next_state = ST_RESET;
      next_count = 12'h000;
    end
  end

  // Registers the sequence and the pin outputs derived from the next state.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state              <= ST_RESET;
      count              <= 12'h000;
      bit_cnt            <= 3'h0;
      shift              <= 8'h00;
      byte_cnt           <= 16'h0000;
      sum                <= 8'h00;
      sclk_d             <= 1'b0;
      uclk_d             <= 1'b0;
      osc                <= 2'h0;
      err_flag           <= 1'b0;
      fault_hold_n_oe    <= 1'b1;
      load_complete_oe   <= 1'b1;
      chain_enable_out_n <= 1'b1;
      io_tristate        <= 1'b1;
      user_mode          <= 1'b0;
    end else begin
      state              <= next_state;
      count              <= next_count;
      bit_cnt            <= next_bit_cnt;
      shift              <= next_shift;
      byte_cnt           <= next_byte_cnt;
      sum                <= next_sum;
      sclk_d             <= pins.sync[PIN_SCLK];
      uclk_d             <= pins.sync[PIN_UCLK];
      osc                <= next_osc;
      err_flag           <= next_err_flag;
      // Fault pulled low in reset and in the error timeout.
      fault_hold_n_oe    <= (next_state == ST_RESET) || (next_state == ST_ERROR);
      // Load-complete held low until the image is good.
      load_complete_oe   <= !((next_state == ST_WAIT_DONE) || (next_state == ST_INIT)
                              || (next_state == ST_USER));
      // Next device in the chain is enabled once we are done.
      chain_enable_out_n <= !((next_state == ST_WAIT_DONE) || (next_state == ST_INIT)
                              || (next_state == ST_USER));
      io_tristate        <= (next_state != ST_USER);
      user_mode          <= (next_state == ST_USER);
    end
  end

  // Open-drain lines only ever drive low; the wire resolves the AND.
  assign fault_hold_n_out  = 1'b0;
  assign load_complete_out = 1'b0;

  // Bus side: one answer per request, dropped the cycle after.
  always_comb begin
    next_ack    = cyc_i & stb_i & ~ack_o;
    next_ctrl   = ctrl;
    next_length = length;
    next_dat    = 32'h0000_0000;
    // Writes take effect at the edge where the master sees the answer.
    if (wr_fire && adr_i == `CFG_OFS_CTRL && sel_i[0]) begin
      next_ctrl = dat_i[1:0];
    end
    if (wr_fire && adr_i == `CFG_OFS_LENGTH) begin
      if (sel_i[0]) begin
        next_length[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        next_length[15:8] = dat_i[15:8];
      end
    end
    // Unmapped offsets still answer and read as zero.
    case (adr_i)
      `CFG_OFS_CTRL:   next_dat[1:0]  = ctrl;
      `CFG_OFS_LENGTH: next_dat[15:0] = length;
      `CFG_OFS_STATUS: begin
        next_dat[`CFG_STAT_STATE_LSB +: 3] = state;
        next_dat[`CFG_STAT_USER_BIT]       = user_mode;
        next_dat[`CFG_STAT_ERR_BIT]        = err_flag;
      end
      `CFG_OFS_COUNT:  next_dat[15:0] = byte_cnt;
      default:         next_dat       = 32'h0000_0000;
    endcase
  end

  // Bus registers; read data is loaded with the answer.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_o  <= 1'b0;
      ctrl   <= `CFG_CTRL_RESET;
      length <= `CFG_LENGTH_RESET;
      dat_o  <= 32'h0000_0000;
    end else begin
      ack_o  <= next_ack;
      ctrl   <= next_ctrl;
      length <= next_length;
      if (next_ack) begin
        dat_o <= next_dat;
      end
    end
  end

endmodule // serial_config_loader

// *** dv/serial_config_props.sv ***
/*
  Checker of the configuration loader ports, bound into every loader instance.
  Assumes the 25 MHz system clock and the constants header on the include path.
*/
`include "serial_config_consts.svh"
module serial_config_props (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Bus side.
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // Configuration pins.
  input wire logic        restart_request_n,
  input wire logic        chain_enable_out_n,
  input wire logic        fault_hold_n_in,
  input wire logic        fault_hold_n_oe,
  input wire logic        load_complete_in,
  input wire logic        load_complete_oe,
  input wire logic        io_tristate,
  input wire logic        user_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  // Fault hold limit, with slack for the input synchronisers.
  localparam int TMO = `CFG_TIMEOUT_CYC + 12;
  logic        auto_on;      // Copy of the automatic restart bit.
  logic        next_auto_on;
  logic [11:0] flt_cnt;      // Cycles the fault pull lasts with restart high.
  logic [11:0] next_flt_cnt;
  logic [10:0] hi_cnt;       // Cycles load-complete has stood high, saturating.
  logic [10:0] next_hi_cnt;

  // Follow control writes at the acknowledge edge, when they take effect.
  always_comb begin
    next_auto_on = auto_on;
    if (cyc_i && stb_i && we_i && ack_o && adr_i == `CFG_OFS_CTRL && sel_i[0]) begin
      next_auto_on = dat_i[`CFG_CTRL_AUTO_BIT];
    end
    next_flt_cnt = (fault_hold_n_oe && restart_request_n) ? flt_cnt + 12'h001 : 12'h000;
    next_hi_cnt = !load_complete_in ? 11'h000 : hi_cnt + {10'h000, hi_cnt != 11'h7FF};
  end

  // Register the helper state.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      auto_on <= 1'h1;
      flt_cnt <= 12'h000;
      hi_cnt  <= 11'h000;
    end else begin
      auto_on <= next_auto_on;
      flt_cnt <= next_flt_cnt;
      hi_cnt  <= next_hi_cnt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_held; fault_hold_n_oe && load_complete_oe && io_tristate && !user_mode; endsequence
  sequence s_ack; ack_o ##1 !ack_o; endsequence
  property p_restart; !restart_request_n [*6] |-> s_held; endproperty
  property p_io; io_tristate != user_mode; endproperty
  property p_rise; $rose(user_mode) |-> load_complete_in && fault_hold_n_in && hi_cnt >= 11'h12B;
  endproperty
  property p_chain; $fell(chain_enable_out_n) |-> ##[0:4] !load_complete_oe; endproperty
  property p_release; $fell(fault_hold_n_oe) |-> restart_request_n && $past(restart_request_n, 2);
  endproperty
  property p_done; $fell(load_complete_oe) |-> fault_hold_n_in && !fault_hold_n_oe; endproperty
  property p_stop;
    (!fault_hold_n_in && !user_mode) [*6] |-> load_complete_oe && chain_enable_out_n;
  endproperty
  property p_tmo; auto_on |-> flt_cnt < TMO; endproperty
  property p_ack; cyc_i && stb_i && !ack_o |=> s_ack; endproperty

  a_restart: assert property (p_restart) else $error("restart low not honoured");
  a_io: assert property (p_io) else $error("pins not tri-stated outside user mode");
  a_rise: assert property (p_rise) else $error("user mode entered too early");
  a_chain: assert property (p_chain) else $error("chain enable out early");
  a_release: assert property (p_release) else $error("fault released under restart");
  a_done: assert property (p_done) else $error("load complete released in fault");
  a_stop: assert property (p_stop) else $error("fault line did not stop the load");
  a_tmo: assert property (p_tmo) else $error("fault held past the timeout");
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
endmodule // serial_config_props

bind serial_config_loader serial_config_props u_props (
  .clk_sys, .arst_n, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
  .restart_request_n, .chain_enable_out_n, .fault_hold_n_in, .fault_hold_n_oe,
  .load_complete_in, .load_complete_oe, .io_tristate, .user_mode);

// *** dv/conf_source_model.sv ***
/*
  Behavioural configuration source: serial clock, lane zero and its own fault pull.
  Assumes the bench resolves the open-drain lines and calls load from one process.
*/
module conf_source_model (
  // Shared open-drain lines as seen on the board.
  input  wire logic fault_line,
  input  wire logic done_line,
  // Serial link; one target, so a single lane.
  output logic      sclk,
  output logic      sdata,
  // The source's own pull on the fault line.
  output logic      src_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic failed;  // Set when load-complete stayed low after the tail.

  // Idle: clock still, data high, line released.
  initial begin
    sclk = 1'h0;
    sdata = 1'h1;
    src_pull = 1'h0;
    failed = 1'h0;
  end

  // Sends n bytes LSB first, additive checksum last; bad corrupts the checksum.
  task automatic load(input int n, input logic bad, input int tail);
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'h00;
    failed = 1'h0;
    wait (!done_line && fault_line);
    #7;
    for (int i = 0; i < n; i++) begin
      b = (i == n - 1) ? sum ^ {7'h00, bad} : 8'hA5 + 8'(i) * 8'h1D;
      sum = sum + b;
      for (int k = 0; k < 8; k++) begin
        sdata = b[k];
        #160 sclk = 1'h1;
        #160 sclk = 1'h0;
        if (!fault_line) return;
      end
    end
    // Keep clocking while load-complete is awaited; data no longer valid.
    repeat (tail) begin
      sdata = ~sdata;
      #160 sclk = 1'h1;
      #160 sclk = 1'h0;
    end
    if (!done_line) begin
      failed = 1'h1;
      src_pull = 1'h1;
      #2000 src_pull = 1'h0;
    end
    sdata = ~sdata;
  endtask
endmodule // conf_source_model

// *** dv/testbench.sv ***
/*
  Self-checking bench of the configuration loader with the source model on its pins.
  Assumes the checker binds itself and the model drives the serial link.
*/
`include "serial_config_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, arst_n, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic        restart_request_n, chain_enable_in_n, uclk, sclk, sdata, src_pull;
  logic        chain_enable_out_n, fault_hold_n_out, fault_hold_n_oe;
  logic        load_complete_out, load_complete_oe, io_tristate, user_mode;
  int          err_count, samples_checked, n;
  // Board lines: pulled up, low while any party drives them.
  wire logic fault_line = (fault_hold_n_oe ? fault_hold_n_out : 1'h1) & !src_pull;
  wire logic done_line = load_complete_oe ? load_complete_out : 1'h1;
  typedef struct { logic [7:0] a; logic w; logic [3:0] s; logic [31:0] d, e; } row_t;
  // Run with restart low: write when w is set, then read back.
  row_t rows [8] = '{'{8'h00, 1'h0, 4'hF, 32'h0, 32'h1}, '{8'h04, 1'h0, 4'hF, 32'h0, 32'h10},
    '{8'h08, 1'h0, 4'hF, 32'h0, 32'h0}, '{8'h0C, 1'h0, 4'hF, 32'h0, 32'h0},
    '{8'h10, 1'h1, 4'hF, 32'h1, 32'h0}, '{8'h04, 1'h1, 4'h3, 32'hFFFF0004, 32'h4},
    '{8'h00, 1'h1, 4'h0, 32'h0, 32'h1}, '{8'h08, 1'h1, 4'hF, 32'hFFFFFFFF, 32'h0}};

  serial_config_loader dut (
    .clk_sys, .arst_n, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .dat_o,
    .serial_load_clock(sclk), .serial_lane_zero(sdata), .restart_request_n,
    .chain_enable_in_n, .user_startup_clock(uclk), .chain_enable_out_n,
    .fault_hold_n_in(fault_line), .fault_hold_n_out, .fault_hold_n_oe,
    .load_complete_in(done_line), .load_complete_out, .load_complete_oe,
    .io_tristate, .user_mode);
  conf_source_model src (.fault_line, .done_line, .sclk, .sdata, .src_pull);

  // System clock at 25 MHz and a free-running user startup clock.
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    uclk = 1'h0;
    forever #50 uclk = ~uclk;
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // Compares with case equality, so an unknown never matches.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One classic cycle; read data is taken at the acknowledge edge.
  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    // No cycle count is assumed; only the watchdog ends a wait that never answers.
    do begin
      @(posedge clk_sys);
    end while (ack_o !== 1'h1);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i <= 1'h0;
  endtask

  // Waits, bounded, for user mode, then looks at the chain and the lines.
  task automatic wait_user();
    n = 0;
    while (user_mode !== 1'h1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk({27'h0, io_tristate, chain_enable_out_n, done_line, fault_line, user_mode},
        32'h7);
  endtask

  // Restart pulse of 2 us: device held while low, fault released after.
  task automatic pulse();
    restart_request_n <= 1'h0;
    tick(50);
    chk({28'h0, fault_hold_n_oe, load_complete_oe, io_tristate, user_mode}, 32'hE);
    restart_request_n <= 1'h1;
    tick(10);
    chk({31'h0, fault_hold_n_oe}, 32'h0);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the expected few hundred microseconds.
  initial begin
    #3000000;
    err_count++;
    give_verdict();
  end

  initial begin
    {arst_n, cyc_i, stb_i, we_i, restart_request_n, chain_enable_in_n} = 6'h0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    err_count = 0;
    samples_checked = 0;
    tick(12);
    arst_n <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) wb(rows[i].a, 1'h1, rows[i].s, rows[i].d);
      wb(rows[i].a, 1'h0, 4'hF, 32'h0);
      chk(rd, rows[i].e);
    end
    $display("register table done");
    // Good load on the internal oscillator.
    restart_request_n <= 1'h1;
    src.load(4, 1'h0, 64);
    wait_user();
    wb(`CFG_OFS_STATUS, 1'h0, 4'hF, 32'h0);
    chk(rd, 32'h16);
    wb(`CFG_OFS_COUNT, 1'h0, 4'hF, 32'h0);
    chk(rd, 32'h4);
    $display("good load done");
    pulse();
    $display("user mode restart done");
    // Bad checksum with automatic restart, then the sticky flag cleared.
    src.load(4, 1'h1, 16);
    wb(`CFG_OFS_STATUS, 1'h0, 4'hF, 32'h0);
    chk(rd & 32'h100, 32'h100);
    wb(`CFG_OFS_STATUS, 1'h1, 4'h2, 32'h100);
    wb(`CFG_OFS_STATUS, 1'h0, 4'hF, 32'h0);
    chk(rd & 32'h100, 32'h0);
    n = 0;
    while (fault_hold_n_oe === 1'h1 && n < 4000) begin
      tick(1);
      n++;
    end
    chk({31'h0, n < `CFG_TIMEOUT_CYC}, 32'h1);
    $display("auto restart done");
    // Automatic restart off: the fault stays until a restart pulse.
    wb(`CFG_OFS_CTRL, 1'h1, 4'h1, 32'h0);
    src.load(4, 1'h1, 16);
    tick(3000);
    chk({31'h0, fault_hold_n_oe}, 32'h1);
    pulse();
    $display("manual restart done");
    // Chain enable high: data ignored, the source times out and pulls the line.
    chain_enable_in_n <= 1'h1;
    src.load(4, 1'h0, 16);
    chk({30'h0, src.failed, user_mode}, 32'h2);
    wb(`CFG_OFS_COUNT, 1'h0, 4'hF, 32'h0);
    chk(rd, 32'h0);
    chain_enable_in_n <= 1'h0;
    $display("chain disabled done");
    // Initialization on the user startup clock.
    wb(`CFG_OFS_CTRL, 1'h1, 4'h1, 32'h2);
    src.load(4, 1'h0, 64);
    wait_user();
    $display("user clock done");
    arst_n <= 1'h0;
    tick(2);
    chk({27'h0, io_tristate, user_mode, chain_enable_out_n, fault_hold_n_oe, load_complete_oe},
        32'h17);
    $display("reset values done");
    give_verdict();
  end
endmodule // testbench
